/* hw/ecd_diag.sv */
// Functional notes
// - Underflow flag sets when the count wraps from the reset value to the limit value.
// - Underflow flag clears once the count is below reset value plus two thirds of the span.
// - Overflow flag sets when the count wraps from the limit value to the reset value.
// - Overflow flag clears once the count is above reset value plus one third of the span.
// - Open-circuit detection runs only in differential input mode.
// - A low differential level on a track counts as an open-circuit error.
// - Each of tracks A, B, C has its own detection enable; disabled tracks raise no error.
// - Group open-circuit flag follows any error on an enabled track.
// - Position-invalid flag is high while position data are invalid.
// - Track A fault flag follows an open-circuit error on track A.
// - Track A indicator is green on a true level and red on an open-circuit error.
// - A track A open-circuit error emits message code 0x831B.
// - Supply-failure flag is high while the encoder supply is absent.
// - Encoder supply indicator is green with supply present, off without.
// - Loss of encoder supply emits message code 0x8303.
`timescale 1ns/10ps
module ecd_diag (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic cnt_update_i,
  input wire logic [ecd_pkg::CNT_W-1:0] count_i,
  input wire logic [ecd_pkg::CNT_W-1:0] reset_value_i,
  input wire logic [ecd_pkg::CNT_W-1:0] limit_value_i,
  input wire logic diff_mode_i,
  input wire ecd_pkg::ecd_track_type track_a_i,
  input wire ecd_pkg::ecd_track_type track_b_i,
  input wire ecd_pkg::ecd_track_type track_c_i,
  input wire logic supply_ok_i,
  output logic underflow_o,
  output logic overflow_o,
  output logic open_circuit_o,
  output logic position_invalid_flag_o,
  output logic track_a_fault_o,
  output logic track_b_fault_o,
  output logic track_c_fault_o,
  output ecd_pkg::ecd_led_type track_a_indicator_o,
  output logic supply_fail_o,
  output ecd_pkg::ecd_led_type encoder_supply_indicator_o,
  output ecd_pkg::ecd_msg_type diag_msg_o
);

  logic err_a;
  logic err_b;
  logic err_c;
  logic next_open;
  logic supply_fail_d;
  logic a_msg_due;
  logic a_msg_wait;

  // Track error when enabled, in differential mode, with low diff level
  function automatic logic track_err(input logic diff_mode, input ecd_pkg::ecd_track_type t);
    track_err = diff_mode && t.enable && t.diff_low;
  endfunction : track_err

  assign err_a = track_err(diff_mode_i, track_a_i);
  assign err_b = track_err(diff_mode_i, track_b_i);
  assign err_c = track_err(diff_mode_i, track_c_i);
  assign next_open = err_a || err_b || err_c;

  // Counter limit diagnostics
  ecd_wrap_detect u_wrap (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .cnt_update_i(cnt_update_i),
    .count_i(count_i),
    .reset_value_i(reset_value_i),
    .limit_value_i(limit_value_i),
    .underflow_o(underflow_o),
    .overflow_o(overflow_o)
  );

  // Open-circuit flags
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      open_circuit_o <= ecd_pkg::RST_FLAG;
      position_invalid_flag_o <= ecd_pkg::RST_FLAG;
      track_a_fault_o <= ecd_pkg::RST_FLAG;
      track_b_fault_o <= ecd_pkg::RST_FLAG;
      track_c_fault_o <= ecd_pkg::RST_FLAG;
    end
    else
    begin
      open_circuit_o <= next_open;
      position_invalid_flag_o <= next_open;
      track_a_fault_o <= err_a;
      track_b_fault_o <= err_b;
      track_c_fault_o <= err_c;
    end
  end

  // Track A indicator: error shows red over the level
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
      track_a_indicator_o <= ecd_pkg::ECD_LED_OFF;
    else if (err_a)
      track_a_indicator_o <= ecd_pkg::ECD_LED_RED;
    else if (track_a_i.level)
      track_a_indicator_o <= ecd_pkg::ECD_LED_GREEN;
    else
      track_a_indicator_o <= ecd_pkg::ECD_LED_OFF;
  end

  // Supply monitoring
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      supply_fail_o <= ecd_pkg::RST_FLAG;
      supply_fail_d <= ecd_pkg::RST_FLAG;
      encoder_supply_indicator_o <= ecd_pkg::ECD_LED_OFF;
    end
    else
    begin
      supply_fail_o <= !supply_ok_i;
      supply_fail_d <= supply_fail_o;
      encoder_supply_indicator_o <= supply_ok_i ? ecd_pkg::ECD_LED_GREEN
        : ecd_pkg::ECD_LED_OFF;
    end
  end

  // Track A onset, or one held back by a supply message in the same cycle
  assign a_msg_due = (err_a && !track_a_fault_o) || a_msg_wait;

  // A track A message that loses the slot to the supply message goes out next cycle
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
      a_msg_wait <= ecd_pkg::RST_FLAG;
    else
      a_msg_wait <= a_msg_due && supply_fail_o && !supply_fail_d;
  end

  // Message strobe on error onset; supply loss takes priority
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
      diag_msg_o <= '0;
    else if (supply_fail_o && !supply_fail_d)
      diag_msg_o <= '{valid: 1'b1, code: ecd_pkg::MSG_SUPPLY_LOST};
    else if (a_msg_due)
      diag_msg_o <= '{valid: 1'b1, code: ecd_pkg::MSG_TRACK_A_OPEN};
    else
      diag_msg_o <= '{valid: 1'b0, code: diag_msg_o.code};
  end

  chk_mode_gate: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    !diff_mode_i |=> !open_circuit_o && !track_a_fault_o)
    else $error("error raised outside differential mode");
  chk_short_error: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    diff_mode_i && track_a_i.enable && track_a_i.diff_low |=> track_a_fault_o)
    else $error("low differential level not flagged");
  chk_enable_gate: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    !track_b_i.enable |=> !track_b_fault_o)
    else $error("disabled track raised error");
  chk_group_flag: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    diff_mode_i && (track_a_i.enable && track_a_i.diff_low
    || track_b_i.enable && track_b_i.diff_low || track_c_i.enable && track_c_i.diff_low)
    |=> open_circuit_o) else $error("group flag not raised");
  chk_invalid_flag: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    position_invalid_flag_o == open_circuit_o)
    else $error("invalid flag mismatch");
  chk_a_fault: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    !err_a |=> !track_a_fault_o) else $error("track A fault stuck");
  chk_a_led: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    track_a_fault_o |-> track_a_indicator_o == ecd_pkg::ECD_LED_RED)
    else $error("track A indicator not red");
  chk_a_msg: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    $rose(track_a_fault_o)
    |-> ##[0:1] (diag_msg_o.valid && diag_msg_o.code == ecd_pkg::MSG_TRACK_A_OPEN))
    else $error("track A message missing");
  chk_supply_flag: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    !supply_ok_i |=> supply_fail_o) else $error("supply fail not flagged");
  chk_supply_led: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    supply_fail_o |-> encoder_supply_indicator_o == ecd_pkg::ECD_LED_OFF)
    else $error("supply indicator not off");
  chk_supply_msg: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    $rose(supply_fail_o) |=> diag_msg_o.valid
    && diag_msg_o.code == ecd_pkg::MSG_SUPPLY_LOST)
    else $error("supply message missing");

  // Further track checks
  chk_bc_mode: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    !diff_mode_i |=> !track_b_fault_o && !track_c_fault_o)
    else $error("track B or C error outside differential mode");
  chk_a_enable: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    !track_a_i.enable |=> !track_a_fault_o)
    else $error("disabled track A raised error");
  chk_c_enable: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    !track_c_i.enable |=> !track_c_fault_o)
    else $error("disabled track C raised error");
  chk_b_set: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    diff_mode_i && track_b_i.enable && track_b_i.diff_low |=> track_b_fault_o)
    else $error("track B low level not flagged");
  chk_c_set: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    diff_mode_i && track_c_i.enable && track_c_i.diff_low |=> track_c_fault_o)
    else $error("track C low level not flagged");
  chk_b_clear: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    !(diff_mode_i && track_b_i.enable && track_b_i.diff_low) |=> !track_b_fault_o)
    else $error("track B fault stuck");
  chk_group_clear: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    !(diff_mode_i && (track_a_i.enable && track_a_i.diff_low
    || track_b_i.enable && track_b_i.diff_low || track_c_i.enable && track_c_i.diff_low))
    |=> !open_circuit_o) else $error("group flag not cleared");
  chk_a_green: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    !err_a && track_a_i.level |=> track_a_indicator_o == ecd_pkg::ECD_LED_GREEN)
    else $error("track A indicator not green");
  chk_a_off: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    !err_a && !track_a_i.level |=> track_a_indicator_o == ecd_pkg::ECD_LED_OFF)
    else $error("track A indicator not off");
  chk_a_msg_late: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    a_msg_wait |=> diag_msg_o.valid && diag_msg_o.code == ecd_pkg::MSG_TRACK_A_OPEN)
    else $error("held track A message missing");
  chk_msg_wait_once: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    a_msg_wait |=> !a_msg_wait) else $error("track A message held too long");

  // Further supply checks
  chk_supply_clear: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    supply_ok_i |=> !supply_fail_o) else $error("supply fail not cleared");
  chk_supply_green: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    supply_ok_i |=> encoder_supply_indicator_o == ecd_pkg::ECD_LED_GREEN)
    else $error("supply indicator not green");

endmodule : ecd_diag

/* hw/ecd_pkg.sv */
package ecd_pkg;

  // Counter and message widths
  localparam int CNT_W = 32;
  localparam int MSG_W = 16;

  // Diagnostic message text codes
  localparam logic [15:0] MSG_TRACK_A_OPEN = 16'h831B;
  localparam logic [15:0] MSG_SUPPLY_LOST = 16'h8303;

  // Indicator colour codes
  typedef enum logic [1:0] {
    ECD_LED_OFF = 2'b00,
    ECD_LED_GREEN = 2'b01,
    ECD_LED_RED = 2'b10
  } ecd_led_type;

  // Reset values of flags
  localparam logic RST_FLAG = 1'b0;

  // Per-track inputs: level, differential-too-low, enable
  typedef struct packed {
    logic level;
    logic diff_low;
    logic enable;
  } ecd_track_type;

  // Diagnostic message strobe with its code
  typedef struct packed {
    logic valid;
    logic [15:0] code;
  } ecd_msg_type;

endpackage : ecd_pkg

/* hw/ecd_wrap_detect.sv */
`timescale 1ns/10ps
// Wrap detection with hysteretic clearing of underflow and overflow flags
module ecd_wrap_detect (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic cnt_update_i,
  input wire logic [ecd_pkg::CNT_W-1:0] count_i,
  input wire logic [ecd_pkg::CNT_W-1:0] reset_value_i,
  input wire logic [ecd_pkg::CNT_W-1:0] limit_value_i,
  output logic underflow_o,
  output logic overflow_o
);

  logic [ecd_pkg::CNT_W-1:0] prev_count;
  logic [ecd_pkg::CNT_W-1:0] third_mark;
  logic [ecd_pkg::CNT_W-1:0] two_third_mark;
  logic wrap_down;
  logic wrap_up;

  // Fraction of the span above the reset value
  function automatic logic [ecd_pkg::CNT_W-1:0] span_mark(
    input logic [ecd_pkg::CNT_W-1:0] lo,
    input logic [ecd_pkg::CNT_W-1:0] hi,
    input logic [1:0] num
  );
    logic [ecd_pkg::CNT_W+1:0] prod;
    logic [ecd_pkg::CNT_W+1:0] quot;
    prod = {2'b00, hi - lo} * {{ecd_pkg::CNT_W{1'b0}}, num};
    quot = prod / 34'h3;
    span_mark = lo + quot[ecd_pkg::CNT_W-1:0];
  endfunction : span_mark

  // Thresholds and wrap events
  assign third_mark = span_mark(reset_value_i, limit_value_i, 2'h1);
  assign two_third_mark = span_mark(reset_value_i, limit_value_i, 2'h2);
  assign wrap_down = cnt_update_i && prev_count == reset_value_i
    && count_i == limit_value_i;
  assign wrap_up = cnt_update_i && prev_count == limit_value_i
    && count_i == reset_value_i;

  // Previous count
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
      prev_count <= '0;
    else if (cnt_update_i)
      prev_count <= count_i;
  end

  // Underflow flag: set wins over clear
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
      underflow_o <= ecd_pkg::RST_FLAG;
    else if (wrap_down)
      underflow_o <= 1'b1;
    else if (cnt_update_i && count_i < two_third_mark)
      underflow_o <= 1'b0;
  end

  // Overflow flag: set wins over clear
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
      overflow_o <= ecd_pkg::RST_FLAG;
    else if (wrap_up)
      overflow_o <= 1'b1;
    else if (cnt_update_i && count_i > third_mark)
      overflow_o <= 1'b0;
  end

  chk_underflow_set: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    wrap_down |=> underflow_o) else $error("underflow not set on wrap");
  chk_underflow_clear: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    cnt_update_i && !wrap_down && count_i < two_third_mark |=> !underflow_o)
    else $error("underflow not cleared");
  chk_overflow_set: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    wrap_up |=> overflow_o) else $error("overflow not set on wrap");
  chk_overflow_clear: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    cnt_update_i && !wrap_up && count_i > third_mark |=> !overflow_o)
    else $error("overflow not cleared");
  chk_flags_hold: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    !cnt_update_i |=> $stable(underflow_o) && $stable(overflow_o))
    else $error("flag changed without count update");

endmodule : ecd_wrap_detect

/* verif/ecd_enc_model.sv */
`timescale 1ns/10ps
// Encoder stand-in: quadrature tracks A and B, index C, with line faults on demand
module ecd_enc_model (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic run_i,
  input wire logic [2:0] break_i,
  input wire logic [2:0] short_i,
  output logic [2:0] level_o,
  output logic [2:0] diff_low_o
);
  logic [1:0] phase;
  logic flip;
  logic [2:0] bad;
  // Phase steps only while running; flip feeds the floating receivers
  always_ff @(posedge core_clk_i)
  begin
    phase <= !rst_n_i ? 2'h0 : phase + {1'h0, run_i};
    flip <= !rst_n_i ? 1'h0 : !flip;
  end
  // A faulty pair has no defined level, so its receiver output wanders
  assign bad = break_i | short_i;
  assign level_o = ({phase == 2'h0, ^phase, phase[1]} & ~bad) | ({3{flip}} & bad);
  // Break and short both collapse the differential level
  assign diff_low_o = bad;
endmodule : ecd_enc_model

/* verif/tb_top.sv */
`timescale 1ns/10ps
// Self-checking bench for the encoder diagnostics block
module tb_top;
  localparam logic [31:0] RV = 32'h190;
  localparam logic [31:0] LV = 32'hFFF;
  localparam logic [31:0] T1 = RV + (LV - RV) / 3;
  localparam logic [31:0] T2 = RV + 2 * (LV - RV) / 3;
  localparam logic [31:0] WCNT [8] = '{RV, LV, T2, T2 - 32'h1, LV, RV, T1, T1 + 32'h1};
  localparam logic [1:0] WEXP [8] = '{2'h0, 2'h2, 2'h2, 2'h0, 2'h0, 2'h1, 2'h1, 2'h0};
  // Row: mode, enables CBA, breaks CBA, supply, group flag, faults CBA
  localparam logic [11:0] ROWS [8] = '{12'hF10, 12'hF39, 12'hF5A, 12'hF9C,
    12'h7F0, 12'h8F0, 12'hE7A, 12'hFEF};
  logic core_clk_i, rst_n, upd, dm, sup, run, uf, of, opn, inv, fa, fb, fc, sfail;
  logic [31:0] cnt;
  logic [2:0] en, brk, sht, lvl, dlow;
  ecd_pkg::ecd_led_type a_led, s_led;
  ecd_pkg::ecd_msg_type msg;
  int failures = 0;
  int tests_run = 0;

  ecd_enc_model i_ecd_enc_model (.core_clk_i(core_clk_i), .rst_n_i(rst_n), .run_i(run),
    .break_i(brk), .short_i(sht), .level_o(lvl), .diff_low_o(dlow));

  ecd_diag i_ecd_diag (.core_clk_i(core_clk_i), .rst_n_i(rst_n), .cnt_update_i(upd),
    .count_i(cnt), .reset_value_i(RV), .limit_value_i(LV), .diff_mode_i(dm),
    .track_a_i({lvl[0], dlow[0], en[0]}), .track_b_i({lvl[1], dlow[1], en[1]}),
    .track_c_i({lvl[2], dlow[2], en[2]}), .supply_ok_i(sup), .underflow_o(uf),
    .overflow_o(of), .open_circuit_o(opn), .position_invalid_flag_o(inv),
    .track_a_fault_o(fa), .track_b_fault_o(fb), .track_c_fault_o(fc),
    .track_a_indicator_o(a_led), .supply_fail_o(sfail),
    .encoder_supply_indicator_o(s_led), .diag_msg_o(msg));

  // Counted comparison
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] %0t got %0h expected %0h", $time, got, exp);
    end
  endtask : chk

  // Every output must sit at zero while held in reset
  task automatic chk_rst;
    chk({uf, of, opn, inv, fa, fb, fc, a_led, sfail, s_led, msg}, 32'h0);
  endtask : chk_rst

  // Wait a few cycles for one message pulse, then see it drop
  task automatic wait_msg(input logic [15:0] code);
    int n;
    n = 0;
    @(negedge core_clk_i);
    while (msg.valid !== 1'h1 && n < 3)
    begin
      @(negedge core_clk_i);
      n++;
    end
    chk(msg, {1'h1, code});
    @(negedge core_clk_i);
    chk(msg.valid, 1'h0);
  endtask : wait_msg

  // Step the encoder phase by two
  task automatic step2;
    run = 1'h1;
    repeat (2) @(negedge core_clk_i);
    run = 1'h0;
  endtask : step2

  // Counts and verdict
  task automatic stop_test;
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : stop_test

  // 50 ns clock
  initial
  begin
    core_clk_i = 1'h0;
    forever #25 core_clk_i = !core_clk_i;
  end

  // Hang guard
  initial
  begin
    repeat (400) @(posedge core_clk_i);
    failures++;
    stop_test();
  end

  // Main sequence
  initial
  begin
    {rst_n, upd, cnt, dm, en, brk, sht, sup, run} = '0;
    repeat (8) @(negedge core_clk_i);
    chk_rst();
    rst_n = 1'h1;
    step2();
    foreach (ROWS[i])
    begin
      {dm, en, brk, sup} = ROWS[i][11:4];
      @(negedge core_clk_i);
      chk(opn, ROWS[i][3]);
      chk(inv, ROWS[i][3]);
      chk({fc, fb, fa}, ROWS[i][2:0]);
      chk(sfail, !ROWS[i][4]);
      chk(s_led, ROWS[i][4] ? ecd_pkg::ECD_LED_GREEN : ecd_pkg::ECD_LED_OFF);
      if (!ROWS[i][5])
        chk(a_led, ROWS[i][0] ? ecd_pkg::ECD_LED_RED : ecd_pkg::ECD_LED_GREEN);
    end
    $display("test diagnostic rows done");
    foreach (WCNT[i])
    begin
      upd = 1'h1;
      cnt = WCNT[i];
      @(negedge core_clk_i);
      upd = 1'h0;
      chk({uf, of}, WEXP[i]);
      @(negedge core_clk_i);
    end
    $display("test wrap flags done");
    {brk, sup} = 4'h1;
    @(negedge core_clk_i);
    sht = 3'h1;
    wait_msg(ecd_pkg::MSG_TRACK_A_OPEN);
    chk(a_led, ecd_pkg::ECD_LED_RED);
    sup = 1'h0;
    wait_msg(ecd_pkg::MSG_SUPPLY_LOST);
    {sht, sup} = 4'h1;
    step2();
    @(negedge core_clk_i);
    chk(a_led, ecd_pkg::ECD_LED_OFF);
    // Supply loss one cycle ahead of a track A short: both messages must come out
    sup = 1'h0;
    @(negedge core_clk_i);
    sht = 3'h1;
    @(negedge core_clk_i);
    chk(msg, {1'h1, ecd_pkg::MSG_SUPPLY_LOST});
    @(negedge core_clk_i);
    chk(msg, {1'h1, ecd_pkg::MSG_TRACK_A_OPEN});
    $display("test messages done");
    {sht, sup} = 4'h2;
    rst_n = 1'h0;
    @(negedge core_clk_i);
    chk_rst();
    // Release in mid-run: outputs follow the held faults from the first edge
    rst_n = 1'h1;
    @(negedge core_clk_i);
    chk({sfail, opn, fa, a_led}, {3'h7, ecd_pkg::ECD_LED_RED});
    chk(msg, {1'h1, ecd_pkg::MSG_TRACK_A_OPEN});
    @(negedge core_clk_i);
    chk(msg, {1'h1, ecd_pkg::MSG_SUPPLY_LOST});
    $display("test reset done");
    stop_test();
  end
endmodule : tb_top
